// *** hw/sdc_core.sv ***
// Purpose: Device side of a four-bank synchronous DRAM command and data interface.
// Assumes: All inputs synchronous to ref_clk; the controller keeps refresh and activate order.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - Sample all commands, addresses, masks and data on the rising clock edge.
// - Clock enable low freezes outputs and burst address from the next cycle.
// - Clock enable dropping with all banks idle enters power-down or self-refresh.
// - Decode commands only while chip select is low; ignore them otherwise.
// - Row strobe low, column high: activate, or precharge with write enable low.
// - Column strobe low, row high starts a column access; write enable picks direction.
// - Read has write enable high, column on low eight lines; write has it low.
// - Bank select picks the bank for activate, read, write and single precharge.
// - Activate latches a twelve-bit row; access latches column and auto-precharge bit.
// - Precharge with auto-precharge bit high closes all banks, otherwise one.
// - Mode register set takes its operating code from the address lines.
// - Mask high floats that byte and blocks storing it during writes.
// - Read mask suppresses the output byte two clock cycles later.
// - Mask bit n governs data bits 8n+7 down to 8n.
// - Each bank holds 4096 rows of 512 columns of 32-bit words.
// - Burst length is 1, 2, 4, 8 or full page; burst stop ends it.
// - Mode selects interleaved or linear order, latency 2 or 3, single writes.
// - Auto-precharge closes the row by itself when a fixed-length burst runs to its end.
`timescale 1ns/1ns

module sdc_core (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic                        chip_sel_n,
  input  wire logic                        row_strobe_n,
  input  wire logic                        col_strobe_n,
  input  wire logic                        write_en_n,
  input  wire logic [sdc_pkg::BANK_W-1:0]  bank_sel,
  input  wire logic [sdc_pkg::ADDR_W-1:0]  addr_lines,
  input  wire logic [sdc_pkg::BYTES-1:0]   byte_mask,
  input  wire logic [sdc_pkg::DATA_W-1:0]  data_in,
  output      logic [sdc_pkg::DATA_W-1:0]  data_out,
  output      logic [sdc_pkg::BYTES-1:0]   data_oe,
  output      logic [sdc_pkg::BANKS-1:0]   bank_idle,
  output      logic                        power_down,
  output      logic                        self_refresh,
  output      logic [sdc_pkg::ADDR_W-1:0]  mode_word
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic                                   cke_prev;
  sdc_pkg::sdc_pmode_t                    pmode;
  sdc_pkg::sdc_cmd_t                      cmd;
  logic                                   run;
  logic                                   all_idle;
  logic                                   acc_now;
  logic                                   stop_hit;
  logic                                   step;
  logic                                   last_step;
  logic                                   ap_fire;
  logic [1:0]                             ap_bank;
  logic                                   single_wr;
  logic [3:0]                             new_len;
  logic                                   new_full;
  logic [sdc_pkg::BANKS-1:0]              bank_open;
  logic [sdc_pkg::BANKS-1:0]              bank_pre;
  logic [sdc_pkg::BANKS-1:0][11:0]        bank_row;
  logic                                   burst_act;
  logic                                   burst_rd;
  logic                                   burst_ap;
  logic                                   burst_full;
  logic                                   burst_ilv;
  logic [1:0]                             burst_bank;
  logic [11:0]                            burst_row;
  logic [8:0]                             burst_start;
  logic [8:0]                             burst_cnt;
  logic [3:0]                             burst_len;
  logic                                   mem_en;
  logic                                   mem_we;
  logic [3:0]                             mem_be;
  logic [sdc_pkg::MEM_AW-1:0]             mem_addr;
  logic [31:0]                            mem_rdata;
  logic                                   rd_v0;
  logic                                   rd_v1;
  logic                                   rd_v2;
  logic [31:0]                            rd_d1;
  logic [31:0]                            rd_d2;
  logic [3:0]                             mask_d1;
  logic [3:0]                             mask_d2;
  logic [11:0]                            mode_r;

  // Column within a burst; wraps inside the burst block, or the whole page.
  function automatic logic [8:0] col_seq(input logic [8:0] start, input logic [8:0] cnt,
                                         input logic [3:0] len, input logic full, input logic ilv);
    logic [8:0] m;
    m = full ? 9'h1FF : 9'(9'(len) - 9'h001);
    if (ilv && !full)
      col_seq = (start & ~m) | ((start ^ cnt) & m);
    else
      col_seq = (start & ~m) | (9'(start + cnt) & m);
  endfunction

  // ***************************************************************
  // Clock enable and power modes
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cke_prev <= 1'b1;
    else
      cke_prev <= clk_en;
  end

  // A low clock enable one edge back stalls every internal register except cke_prev and pmode.
  assign run      = cke_prev && (pmode == sdc_pkg::PM_RUN);
  assign all_idle = (bank_open == 4'h0) && (bank_pre == 4'h0) && !burst_act;

  // Exit is sampled on the clock here; a stopped clock would need an async path.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pmode <= sdc_pkg::PM_RUN;
    else
      case (pmode)
        sdc_pkg::PM_RUN:
          if (cke_prev && !clk_en && all_idle)
            pmode <= (cmd == sdc_pkg::CMD_REF) ? sdc_pkg::PM_SELF : sdc_pkg::PM_PDOWN;
        default:
          if (clk_en)
            pmode <= sdc_pkg::PM_RUN;
      endcase
  end

  // ***************************************************************
  // Command decode
  // ***************************************************************
  always_comb
  begin
    cmd = sdc_pkg::CMD_NOP;
    if (!chip_sel_n)
      case ({row_strobe_n, col_strobe_n, write_en_n})
        3'h3:    cmd = sdc_pkg::CMD_ACT;
        3'h2:    cmd = sdc_pkg::CMD_PRE;
        3'h5:    cmd = sdc_pkg::CMD_READ;
        3'h4:    cmd = sdc_pkg::CMD_WRITE;
        3'h0:    cmd = sdc_pkg::CMD_MRS;
        3'h6:    cmd = sdc_pkg::CMD_STOP;
        3'h1:    cmd = sdc_pkg::CMD_REF;
        default: cmd = sdc_pkg::CMD_NOP;
      endcase
  end

  assign single_wr = (cmd == sdc_pkg::CMD_WRITE) && mode_r[sdc_pkg::MR_WB_BIT];
  assign new_len   = single_wr ? 4'h1 : sdc_pkg::sdc_burst_words(mode_r[sdc_pkg::MR_BL_LSB +: 3]);
  assign new_full  = !single_wr && (mode_r[sdc_pkg::MR_BL_LSB +: 3] == sdc_pkg::BL_FULL);
  // Access to a closed bank is dropped; the controller must activate first.
  assign acc_now   = run && ((cmd == sdc_pkg::CMD_READ) || (cmd == sdc_pkg::CMD_WRITE))
                     && bank_open[bank_sel];
  assign stop_hit  = run && ((cmd == sdc_pkg::CMD_STOP) || ((cmd == sdc_pkg::CMD_PRE)
                     && (addr_lines[sdc_pkg::AP_BIT] || (bank_sel == burst_bank))));
  assign step      = run && burst_act && !acc_now && !stop_hit;
  assign last_step = step && !burst_full && (burst_cnt == 9'(9'(burst_len) - 9'h001));
  assign ap_fire   = (last_step && burst_ap)
                     || (acc_now && addr_lines[sdc_pkg::AP_BIT] && (new_len == 4'h1) && !new_full);
  assign ap_bank   = acc_now ? bank_sel : burst_bank;

  // ***************************************************************
  // Banks
  // ***************************************************************
  for (genvar b = 0; b < sdc_pkg::BANKS; b++)
  begin : g_bank
    logic       open;
    logic [11:0] row;
    logic [1:0] pcnt;
    logic       hit_act;
    logic       hit_pre;

    assign hit_act = run && (cmd == sdc_pkg::CMD_ACT) && (bank_sel == 2'(b)) && !open && (pcnt == 2'h0);
    assign hit_pre = (run && (cmd == sdc_pkg::CMD_PRE) && (addr_lines[sdc_pkg::AP_BIT]
                     || (bank_sel == 2'(b)))) || (ap_fire && (ap_bank == 2'(b)));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        open <= 1'b0;
        row  <= 12'h000;
        pcnt <= 2'h0;
      end
      else if (hit_pre)
      begin
        if (open)
          pcnt <= sdc_pkg::PRE_CYC;
        open <= 1'b0;
      end
      else if (hit_act)
      begin
        open <= 1'b1;
        row  <= addr_lines;
      end
      else if (run && (pcnt != 2'h0))
        pcnt <= pcnt - 2'h1;
    end

    assign bank_open[b] = open;
    assign bank_pre[b]  = (pcnt != 2'h0);
    assign bank_row[b]  = row;
  end

  assign bank_idle = ~bank_open & ~bank_pre;

  // ***************************************************************
  // Mode register
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= sdc_pkg::MR_RESET;
    else if (run && (cmd == sdc_pkg::CMD_MRS) && all_idle)
      mode_r <= addr_lines;
  end

  assign mode_word = mode_r;

  // ***************************************************************
  // Burst engine
  // ***************************************************************
  // Word 0 is taken with the command; the counter then names the next word.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burst_act   <= 1'b0;
      burst_rd    <= 1'b0;
      burst_ap    <= 1'b0;
      burst_full  <= 1'b0;
      burst_ilv   <= 1'b0;
      burst_bank  <= 2'h0;
      burst_row   <= 12'h000;
      burst_start <= 9'h000;
      burst_cnt   <= 9'h000;
      burst_len   <= 4'h1;
    end
    else if (acc_now)
    begin
      burst_act   <= new_full || (new_len != 4'h1);
      burst_rd    <= (cmd == sdc_pkg::CMD_READ);
      burst_ap    <= addr_lines[sdc_pkg::AP_BIT];
      burst_full  <= new_full;
      burst_ilv   <= mode_r[sdc_pkg::MR_BT_BIT];
      burst_bank  <= bank_sel;
      burst_row   <= bank_row[bank_sel];
      burst_start <= {1'b0, addr_lines[sdc_pkg::COL_LINES-1:0]};
      burst_cnt   <= 9'h001;
      burst_len   <= new_len;
    end
    else if (stop_hit)
      burst_act <= 1'b0;
    else if (step)
    begin
      burst_cnt <= burst_cnt + 9'h001;
      if (last_step)
        burst_act <= 1'b0;
    end
  end

  // ***************************************************************
  // Array access
  // ***************************************************************
  assign mem_en   = acc_now || step;
  assign mem_we   = acc_now ? (cmd == sdc_pkg::CMD_WRITE) : !burst_rd;
  assign mem_be   = mem_we ? ~byte_mask : 4'h0;
  assign mem_addr = acc_now ? {bank_sel, bank_row[bank_sel], 1'b0, addr_lines[sdc_pkg::COL_LINES-1:0]}
                            : {burst_bank, burst_row,
                               col_seq(burst_start, burst_cnt, burst_len, burst_full, burst_ilv)};

  sdc_mem u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .en      (mem_en),
    .we      (mem_we),
    .be      (mem_be),
    .addr    (mem_addr),
    .wdata   (data_in),
    .rdata   (mem_rdata)
  );

  // ***************************************************************
  // Read pipeline and output drivers
  // ***************************************************************
  // The pipeline holds still under suspend so no read word is dropped.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_v0   <= 1'b0;
      rd_v1   <= 1'b0;
      rd_v2   <= 1'b0;
      rd_d1   <= 32'h00000000;
      rd_d2   <= 32'h00000000;
      mask_d1 <= 4'h0;
      mask_d2 <= 4'h0;
    end
    else if (run)
    begin
      rd_v0   <= mem_en && !mem_we;
      rd_v1   <= rd_v0;
      rd_v2   <= rd_v1;
      rd_d1   <= mem_rdata;
      rd_d2   <= rd_d1;
      mask_d1 <= byte_mask;
      mask_d2 <= mask_d1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_out <= 32'h00000000;
      data_oe  <= 4'h0;
    end
    else if (run)
    begin
      if (mode_r[sdc_pkg::MR_CL_LSB +: 3] == sdc_pkg::CL_3)
      begin
        data_out <= rd_d2;
        data_oe  <= {4{rd_v2}} & ~mask_d2;
      end
      else
      begin
        data_out <= rd_d1;
        data_oe  <= {4{rd_v1}} & ~mask_d2;
      end
    end
  end

  assign power_down   = (pmode == sdc_pkg::PM_PDOWN);
  assign self_refresh = (pmode == sdc_pkg::PM_SELF);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_suspend_freeze;
    @(posedge ref_clk) disable iff (!rst_n)
    !cke_prev |=> $stable(data_out) && $stable(data_oe) && $stable(burst_cnt);
  endproperty
  a_suspend_freeze: assert property (p_suspend_freeze) else $error("state moved under suspend");

  property p_pdown_entry;
    @(posedge ref_clk) disable iff (!rst_n)
    (pmode == sdc_pkg::PM_RUN) && cke_prev && !clk_en && all_idle |=> power_down || self_refresh;
  endproperty
  a_pdown_entry: assert property (p_pdown_entry) else $error("no power mode entry");

  property p_deselect;
    @(posedge ref_clk) disable iff (!rst_n)
    chip_sel_n |=> $stable(mode_r);
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselected command acted");

  property p_activate;
    @(posedge ref_clk) disable iff (!rst_n)
    run && (cmd == sdc_pkg::CMD_ACT) && bank_idle[bank_sel] |=> bank_open[$past(bank_sel)];
  endproperty
  a_activate: assert property (p_activate) else $error("activate did not open bank");

  property p_precharge_all;
    @(posedge ref_clk) disable iff (!rst_n)
    run && (cmd == sdc_pkg::CMD_PRE) && addr_lines[sdc_pkg::AP_BIT] |=> (bank_open == 4'h0) ##3 (bank_pre == 4'h0);
  endproperty
  a_precharge_all: assert property (p_precharge_all) else $error("precharge all failed");

  property p_mode_set;
    @(posedge ref_clk) disable iff (!rst_n)
    run && (cmd == sdc_pkg::CMD_MRS) && all_idle |=> mode_r == $past(addr_lines);
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode word not loaded");

  property p_read_mask;
    @(posedge ref_clk) disable iff (!rst_n)
    (run && (byte_mask != 4'h0)) ##1 run ##1 run |=> ((data_oe & $past(byte_mask, 3)) == 4'h0);
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("masked byte driven");

  property p_cl2_read;
    @(posedge ref_clk) disable iff (!rst_n)
    (acc_now && (cmd == sdc_pkg::CMD_READ) && (byte_mask == 4'h0) && (mode_r[6:4] != sdc_pkg::CL_3))
    ##1 run ##1 run |=> (data_oe == 4'hF);
  endproperty
  a_cl2_read: assert property (p_cl2_read) else $error("read data late or early");

  property p_burst_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    stop_hit && !acc_now |=> !burst_act;
  endproperty
  a_burst_stop: assert property (p_burst_stop) else $error("burst not stopped");

  property p_auto_pre;
    @(posedge ref_clk) disable iff (!rst_n)
    ap_fire |=> !bank_open[$past(ap_bank)] ##3 bank_idle[$past(ap_bank, 4)];
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("auto precharge missing");

endmodule

// *** hw/sdc_pkg.sv ***
// Purpose: Shared constants and types of the synchronous DRAM command interface.
// Assumes: One clock at 125 MHz; mode word layout chosen for this block.
// Notes:   Geometry, mode word field positions, the mode word reset value and the precharge count live here.

package sdc_pkg;

  // ***************************************************************
  // Geometry
  // ***************************************************************
  localparam int BANKS     = 4;
  localparam int BANK_W    = 2;
  localparam int ROW_W     = 12;
  localparam int COL_W     = 9;
  localparam int COL_LINES = 8;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int BYTES     = 4;
  localparam int MEM_AW    = BANK_W + ROW_W + COL_W;
  localparam int AP_BIT    = 10;

  // ***************************************************************
  // Mode word fields
  // ***************************************************************
  localparam int MR_BL_LSB = 0;
  localparam int MR_BL_W   = 3;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_CL_W   = 3;
  localparam int MR_WB_BIT = 9;

  localparam logic [ADDR_W-1:0]  MR_RESET = 12'h022;
  localparam logic [MR_BL_W-1:0] BL_1     = 3'h0;
  localparam logic [MR_BL_W-1:0] BL_2     = 3'h1;
  localparam logic [MR_BL_W-1:0] BL_4     = 3'h2;
  localparam logic [MR_BL_W-1:0] BL_8     = 3'h3;
  localparam logic [MR_BL_W-1:0] BL_FULL  = 3'h7;
  localparam logic [MR_CL_W-1:0] CL_3     = 3'h3;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PRECHARGE_NS  = 20;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PRE_CYC = 2'(PRECHARGE_CYC);

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_PRE,
    CMD_READ,
    CMD_WRITE,
    CMD_MRS,
    CMD_STOP,
    CMD_REF
  } sdc_cmd_t;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_PDOWN,
    PM_SELF
  } sdc_pmode_t;

  // Words in one burst for a length code; full page is flagged separately.
  function automatic logic [3:0] sdc_burst_words(input logic [MR_BL_W-1:0] code);
    case (code)
      BL_2:    sdc_burst_words = 4'h2;
      BL_4:    sdc_burst_words = 4'h4;
      BL_8:    sdc_burst_words = 4'h8;
      default: sdc_burst_words = 4'h1;
    endcase
  endfunction

endpackage

// *** hw/sdc_mem.sv ***
// Purpose: Storage array of all four banks with byte-lane writes.
// Assumes: One access per cycle; read data leave a register one edge later.
// Notes:   The array itself has no reset; only the read register does.
`timescale 1ns/1ns

module sdc_mem (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        en,
  input  wire logic                        we,
  input  wire logic [sdc_pkg::BYTES-1:0]   be,
  input  wire logic [sdc_pkg::MEM_AW-1:0]  addr,
  input  wire logic [sdc_pkg::DATA_W-1:0]  wdata,
  output      logic [sdc_pkg::DATA_W-1:0]  rdata
);

  logic [sdc_pkg::DATA_W-1:0] store [2**sdc_pkg::MEM_AW];

  // One process owns the whole array; a process per lane would give it four drivers.
  always_ff @(posedge ref_clk)
  begin
    if (en && we)
    begin
      for (int i = 0; i < sdc_pkg::BYTES; i++)
      begin
        if (be[i])
          store[addr][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h00000000;
    end
    else if (en && !we)
    begin
      rdata <= store[addr];
    end
  end

endmodule

// *** tb/sdc_ctrl_model.sv ***
// Purpose: Memory controller model that drives the command, mask and data pins.
// Assumes: Pins change at the falling edge of ref_clk, one command per cycle.
// Notes:   Released address and data lines carry the inverse of their last value, never a stale copy.
`timescale 1ns/1ns

module sdc_ctrl_model (
  input  wire logic        ref_clk,
  output      logic        clk_en,
  output      logic        chip_sel_n,
  output      logic        row_strobe_n,
  output      logic        col_strobe_n,
  output      logic        write_en_n,
  output      logic [1:0]  bank_sel,
  output      logic [11:0] addr_lines,
  output      logic [3:0]  byte_mask,
  output      logic [31:0] data_in
);
  logic [3:0] open_rows;

  task automatic drive(input logic c, input logic [2:0] rcw, input logic [1:0] b, input logic [11:0] a,
                       input logic [3:0] m, input logic [31:0] d);
    chip_sel_n = c;
    {row_strobe_n, col_strobe_n, write_en_n} = rcw;
    bank_sel = b;
    addr_lines = a;
    byte_mask = m;
    data_in = d;
  endtask

  // ***************************************************************
  // Commands
  // ***************************************************************
  task automatic cmd(input logic c, input logic [2:0] rcw, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m, input logic [31:0] d);
    // A column access to a closed bank is preceded by an activate of row zero.
    if (!c && rcw[2:1] == 2'b10 && !open_rows[b])
      cmd(1'b0, 3'b011, b, 12'h000, 4'h0, ~data_in);
    @(negedge ref_clk);
    if (!c && rcw == 3'b011)
      open_rows[b] = 1'b1;
    if (!c && rcw == 3'b010)
      open_rows = a[10] ? 4'h0 : open_rows & ~(4'h1 << b);
    drive(c, rcw, b, a, m, d);
  endtask

  task automatic nop;
    cmd(1'b1, 3'b111, 2'h0, ~addr_lines, 4'h0, ~data_in);
  endtask

  task automatic cke_flip;
    @(negedge ref_clk);
    clk_en = ~clk_en;
  endtask

  // Runs are far shorter than one refresh period, so self refresh alone keeps the array.
  task automatic self_refresh_entry;
    @(negedge ref_clk);
    clk_en = 1'b0;
    drive(1'b0, 3'b001, 2'h0, 12'h000, 4'h0, ~data_in);
  endtask

  initial
  begin
    open_rows = 4'h0;
    clk_en = 1'b1;
    drive(1'b1, 3'b111, 2'h0, 12'h000, 4'h0, 32'h0);
  end
endmodule

// *** tb/sdram_command_interface_bench.sv ***
// Purpose: Self-checking bench of the DRAM command interface driven by a controller model.
// Assumes: Mode word 0x032 gives linear bursts of four words at latency three.
// Notes:   Clock suspend, burst stop and auto precharge are also judged at the pins.
`timescale 1ns/1ns

module sdram_command_interface_bench;
  logic        ref_clk;
  logic        rst_n;
  logic        clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n;
  logic [1:0]  bank_sel;
  logic [11:0] addr_lines, mode_word;
  logic [3:0]  byte_mask, data_oe, bank_idle;
  logic [31:0] data_in, data_out;
  logic        power_down, self_refresh;
  int          fail_count;
  int          n_tests;

  sdc_ctrl_model ctl (.ref_clk(ref_clk), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
    .bank_sel(bank_sel), .addr_lines(addr_lines), .byte_mask(byte_mask), .data_in(data_in));

  sdc_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
    .bank_sel(bank_sel), .addr_lines(addr_lines), .byte_mask(byte_mask), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .bank_idle(bank_idle), .power_down(power_down),
    .self_refresh(self_refresh), .mode_word(mode_word));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_setup;
    chk("mode_word", 32'h022, 32'(mode_word));
    chk("bank_idle", 32'hF, 32'(bank_idle));
    chk("data_oe", 32'h0, 32'(data_oe));
    ctl.cmd(1'b0, 3'b000, 2'h0, 12'h032, 4'h0, ~data_in);
    ctl.nop;
    chk("mode_word", 32'h032, 32'(mode_word));
    ctl.cmd(1'b1, 3'b011, 2'h2, 12'h0AB, 4'h0, ~data_in);
    ctl.nop;
    chk("bank_idle", 32'hF, 32'(bank_idle));
    ctl.cmd(1'b0, 3'b011, 2'h1, 12'hFFF, 4'h0, ~data_in);
    ctl.nop;
    chk("bank_idle", 32'hD, 32'(bank_idle));
    $display("test setup done");
  endtask

  task automatic wr(input logic [31:0] base, input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      ctl.cmd(i != 0, (i == 0) ? 3'b100 : 3'b111, 2'h1, 12'h004, (i == 1) ? m : 4'h0, base + 32'(i));
  endtask

  task automatic t_burst;
    logic [31:0] exp;
    logic [3:0]  eoe;
    wr(32'hA0A0A0A0, 4'h0);
    wr(32'h5B5B5B5B, 4'h4);
    ctl.cmd(1'b0, 3'b101, 2'h1, 12'h004, 4'h0, ~data_in);
    ctl.nop;
    ctl.cmd(1'b1, 3'b111, 2'h0, ~addr_lines, 4'h1, ~data_in);
    ctl.nop;
    // Word one comes after the edge two cycles past the masked one, so only its low byte floats.
    for (int i = 0; i < 4; i++)
    begin
      ctl.nop;
      eoe = (i == 1) ? 4'hE : 4'hF;
      exp = (i == 1) ? 32'h5BA05B00 : 32'h5B5B5B5B + 32'(i);
      chk("data_oe", 32'(eoe), 32'(data_oe));
      chk("data_out", exp, data_out & {{8{eoe[3]}}, {8{eoe[2]}}, {8{eoe[1]}}, {8{eoe[0]}}});
    end
    ctl.nop;
    chk("data_oe", 32'h0, 32'(data_oe));
    $display("test burst done");
  endtask

  task automatic t_precharge;
    ctl.cmd(1'b0, 3'b010, 2'h0, 12'h400, 4'h0, ~data_in);
    ctl.nop;
    chk("bank_idle", 32'hD, 32'(bank_idle));
    for (int k = 0; k < 6 && bank_idle !== 4'hF; k++)
      ctl.nop;
    chk("bank_idle", 32'hF, 32'(bank_idle));
    if (bank_idle !== 4'hF)
      report_and_stop;
    $display("test precharge done");
  endtask

  task automatic t_power;
    ctl.cke_flip;
    ctl.nop;
    chk("power_down", 32'h1, 32'(power_down));
    ctl.cke_flip;
    ctl.nop;
    ctl.nop;
    chk("power_down", 32'h0, 32'(power_down));
    ctl.self_refresh_entry;
    ctl.nop;
    chk("self_refresh", 32'h1, 32'(self_refresh));
    ctl.cke_flip;
    ctl.nop;
    ctl.nop;
    chk("self_refresh", 32'h0, 32'(self_refresh));
    $display("test power done");
  endtask

  task automatic t_modes;
    ctl.cmd(1'b0, 3'b000, 2'h0, 12'h22A, 4'h0, ~data_in);
    ctl.cmd(1'b0, 3'b011, 2'h1, 12'hFFF, 4'h0, ~data_in);
    chk("mode_word", 32'h22A, 32'(mode_word));
    // Latency two, interleaved from column five, closing the row by itself at the end.
    ctl.cmd(1'b0, 3'b101, 2'h1, 12'h405, 4'h0, ~data_in);
    ctl.nop;
    ctl.nop;
    for (int i = 0; i < 4; i++)
    begin
      ctl.nop;
      chk("data_out", ((i ^ 1) == 1) ? 32'h5BA05B5C : 32'h5B5B5B5B + 32'(i ^ 1), data_out);
    end
    ctl.nop;
    chk("bank_idle", 32'hF, 32'(bank_idle));
    chk("data_oe", 32'h0, 32'(data_oe));
    // A single-word write, then a read frozen for one edge and stopped after its third word.
    ctl.cmd(1'b0, 3'b011, 2'h1, 12'hFFF, 4'h0, ~data_in);
    ctl.cmd(1'b0, 3'b100, 2'h1, 12'h004, 4'h0, 32'h13579BDF);
    ctl.nop;
    ctl.cmd(1'b0, 3'b101, 2'h1, 12'h004, 4'h0, ~data_in);
    ctl.nop;
    ctl.cke_flip;
    ctl.cke_flip;
    ctl.cmd(1'b0, 3'b110, 2'h0, ~addr_lines, 4'h0, ~data_in);
    chk("data_out", 32'h13579BDF, data_out);
    ctl.nop;
    chk("data_out", 32'h5BA05B5C, data_out);
    ctl.nop;
    chk("data_out", 32'h5B5B5B5D, data_out);
    ctl.nop;
    chk("data_oe", 32'h0, 32'(data_oe));
    $display("test modes done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_setup;
    t_burst;
    t_precharge;
    t_power;
    t_modes;
    report_and_stop;
  end
endmodule
